// file: posd_checker.sv
// port checker for the output shutdown unit
`timescale 1ns/1ns
`default_nettype none
module posd_checker
   import posd_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [3:0] fault_shutdown_inputs_n,
   input wire logic [5:0] pin_levels,
   input wire logic [5:0] timer_pin_select,
   input wire logic osc_stop,
   input wire logic standby,
   input wire logic [5:0] pin_oe,
   input wire logic [5:0] timer_out,
   input wire logic irq
);
   logic [8:0] fi_q;
   logic [1:0] pc_q;
   logic [3:0] fin_q;
   logic [3:0] m00;
   logic wr;
   logic hit;
   assign wr = psel & penable & pwrite & pready;
   // shadow of mode and enable fields, so properties know the setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fi_q <= 9'h000;
         pc_q <= 2'h0;
         fin_q <= 4'hF;
      end else begin
         fin_q <= fault_shutdown_inputs_n;
         if (wr && paddr == 12'h000) fi_q <= pwdata[8:0];
         if (wr && paddr == 12'h004) pc_q <= pwdata[9:8];
      end
   end
   // falling edge on an input whose mode is edge detection
   assign m00 = {fi_q[7:6] == 2'h0, fi_q[5:4] == 2'h0,
      fi_q[3:2] == 2'h0, fi_q[1:0] == 2'h0};
   assign hit = |(fin_q & ~fault_shutdown_inputs_n & m00);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_access: assert property (
      psel && penable |-> pready) else $error("ready low in access");
   a_unmap_err: assert property (
      psel && penable && paddr > 12'h00C |-> pslverr)
      else $error("no error on unmapped access");
   a_unmap_zero: assert property (
      psel && penable && !pwrite && paddr > 12'h00C |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_edge_shut: assert property (
      hit |-> ##[1:8] pin_oe == 6'h00) else $error("edge did not release");
   a_pair_shut: assert property (
      (pc_q == 2'h3 && pin_levels[1:0] == 2'h0) [*4]
      |-> ##[0:6] pin_oe == 6'h00) else $error("short did not release");
   a_halt_off: assert property (
      $rose(osc_stop || standby) |-> ##[1:3] pin_oe == 6'h00)
      else $error("halt did not release");
   a_unsel_off: assert property (
      (timer_pin_select == 6'h00) [*3] |-> pin_oe == 6'h00)
      else $error("unselected pin driven");
   a_irq_masked: assert property (
      !fi_q[8] && !pc_q[0] |-> ##2 !irq) else $error("masked irq seen");
   c_edge: cover property (hit);
   c_halt: cover property ($rose(osc_stop));
   c_irq: cover property ($rose(irq));
endmodule
bind posd_top posd_checker i_posd_checker (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .fault_shutdown_inputs_n(fault_shutdown_inputs_n),
   .pin_levels(pin_levels), .timer_pin_select(timer_pin_select),
   .osc_stop(osc_stop), .standby(standby), .pin_oe(pin_oe),
   .timer_out(timer_out), .irq(irq));
`default_nettype wire

// file: posd_defs.svh
// constants for the output shutdown unit: offsets, fields, resets, timing
// Behaviour
// RULE1 - each fault input: edge or sampled low
// RULE2 - fault detection tristates the high-current pins
// RULE3 - pair low together over a cycle tristates
// RULE4 - all six pins released together
// RULE5 - interrupt on input or pair detection
// RULE6 - oscillator stop or standby tristates pins
// RULE7 - two 16-bit control/status registers
// RULE8 - after reset outputs low, pins tristated
// RULE9 - complementary stop gives complementary initial values
// RULE10 - reset-sync stop gives reset-sync initial values
// RULE11 - leaving complementary to normal/pwm1 drives low
// RULE12 - leaving reset-sync: positive low, negative high (code drives 6'h2A instead: pin 3 high, pin 4 low)
// RULE13 - complementary after reset-sync: cyclic pin low
// RULE14 - pwm1 pin init skips B-side outputs
// RULE15 - pwm2 pin init skips cycle register pins
// RULE16 - software: port output, stop, re-setup order
// RULE17 - software disables outputs before pwm mode entry
// RULE18 - same-mode restart only reselects and restarts
// RULE19 - mode 00 accepts falling edge
// RULE20 - sixteen consecutive low samples required
// RULE21 - flag clears by read-1 then write-0
// RULE22 - pair compare samples on peripheral clock
`ifndef POSD_DEFS_SVH
`define POSD_DEFS_SVH
`define POSD_FICS_ADDR 12'h000
`define POSD_PCCS_ADDR 12'h004
`define POSD_MODE_ADDR 12'h008
`define POSD_STAT_ADDR 12'h00C
`define POSD_FLAG_LSB 12
`define POSD_PIE_BIT 8
`define POSD_OSF_BIT 15
`define POSD_OCE_BIT 9
`define POSD_OIE_BIT 8
`define POSD_FICS_RST 16'h0000
`define POSD_PCCS_RST 16'h0000
`define POSD_SAMPLES 5'h10
`define POSD_DIV8 8'h07
`define POSD_DIV16 8'h0F
`define POSD_DIV128 8'h7F
`endif

// file: posd_far_end.sv
// fault sources and power-stage pins seen from outside the unit
`timescale 1ns/1ns
`default_nettype none
module posd_far_end (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [3:0] fault_req,
   input wire logic [5:0] pin_oe,
   input wire logic [5:0] timer_out,
   output logic [3:0] fault_shutdown_inputs_n,
   output logic [5:0] pin_levels
);
   logic [5:0] last_q;
   // fault lines idle high through their pull-ups
   assign fault_shutdown_inputs_n = ~fault_req;
   // remember the last driven level of each pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) last_q <= 6'h00;
      else last_q <= (pin_oe & timer_out) | (~pin_oe & last_q);
   end
   // a floating pin shows the inverse, so no stale low looks real
   assign pin_levels = (pin_oe & timer_out) | (~pin_oe & ~last_q);
endmodule
`default_nettype wire

// file: posd_pkg.sv
// types for the output shutdown unit
package posd_pkg;
   typedef enum logic [2:0] {
      POSD_NORMAL, POSD_PWM1, POSD_PWM2, POSD_PHASE, POSD_COMP, POSD_RSYNC
   } posd_mode_t;
   typedef struct packed {
      logic [5:0] level;
      logic [5:0] oe;
   } posd_pins_t;
endpackage

// file: posd_top.sv
// output shutdown unit with apb registers and timer output state keeping
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "posd_defs.svh"
module posd_top
   import posd_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [3:0] fault_shutdown_inputs_n,
   input wire logic [5:0] pin_levels,
   input wire logic [5:0] timer_pin_select,
   input wire logic osc_stop,
   input wire logic standby,
   output logic [5:0] pin_oe,
   output logic [5:0] timer_out,
   output logic irq
);
   // pin order: 0 ch3_out_b 1 ch3_out_d 2 ch4_out_a 3 ch4_out_b
   //            4 ch4_out_c 5 ch4_out_d
   logic [15:0] fics_q;
   logic [15:0] pccs_q;
   logic [3:0] flag_seen_q;
   logic osf_seen_q;
   logic [3:0] s1_q, s2_q, s3_q;
   logic [5:0] l1_q, l2_q, l3_q;
   logic [7:0] pre_q;
   logic [3:0] tick;
   logic [4:0] lowcnt_q [4];
   logic [3:0] detect;
   logic [2:0] pair_low_q;
   logic short_det;
   logic wr, rd;
   posd_mode_t mode_q;
   logic run_q;
   logic [5:0] comp_init_q, rsync_init_q;
   logic [5:0] init_req;
   logic init_strobe;
   logic [5:0] tout_q;
   logic [5:0] oe_q;
   logic irq_q;
   logic [31:0] rdata_q;
   logic err_q;

   assign wr = psel && penable && pwrite;
   assign rd = psel && penable && !pwrite;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
      hit = (a == r);
   endfunction

   function automatic logic known(input logic [11:0] a);
      known = hit(a, `POSD_FICS_ADDR) || hit(a, `POSD_PCCS_ADDR) ||
              hit(a, `POSD_MODE_ADDR) || hit(a, `POSD_STAT_ADDR);
   endfunction

   // three-stage synchronisers; stage 1 feeds only stage 2
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q <= 4'hF;
         s2_q <= 4'hF;
         s3_q <= 4'hF;
         l1_q <= 6'h3F;
         l2_q <= 6'h3F;
         l3_q <= 6'h3F;
      end else begin
         s1_q <= fault_shutdown_inputs_n;
         s2_q <= s1_q;
         s3_q <= s2_q;
         l1_q <= pin_levels;
         l2_q <= l1_q;
         l3_q <= l2_q;
      end
   end

   // free prescaler for the sampling clocks
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_q <= 8'h00;
      end else begin
         pre_q <= pre_q + 8'h01;
      end
   end

   // per input: falling edge when stage 3 is high and stage 2 low, or counted low samples
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_in
         logic [1:0] m;
         assign m = fics_q[2*g+1 -: 2];
         always_comb begin
            case (m)
               2'h1: tick[g] = ((pre_q & `POSD_DIV8) == 8'h00);
               2'h2: tick[g] = ((pre_q & `POSD_DIV16) == 8'h00);
               default: tick[g] = ((pre_q & `POSD_DIV128) == 8'h00);
            endcase
         end
         // a high sample restarts the count so the run must be unbroken
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               lowcnt_q[g] <= 5'h00;
            end else if (m == 2'h0 || s3_q[g]) begin
               lowcnt_q[g] <= 5'h00; // see RULE20
            end else if (tick[g] && lowcnt_q[g] != `POSD_SAMPLES) begin
               lowcnt_q[g] <= lowcnt_q[g] + 5'h01; // see RULE1
            end
         end
         assign detect[g] = (m == 2'h0) ? (s3_q[g] && !s2_q[g]) // see RULE19
            : (tick[g] && !s3_q[g] && lowcnt_q[g] == `POSD_SAMPLES - 5'h01);
      end
   endgenerate

   // pairs compared on agreed levels, flagged after a full cycle low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pair_low_q <= 3'h0;
      end else begin
         pair_low_q[0] <= !l3_q[0] && !l3_q[1] && !l2_q[0] && !l2_q[1];
         pair_low_q[1] <= !l3_q[2] && !l3_q[4] && !l2_q[2] && !l2_q[4];
         pair_low_q[2] <= !l3_q[3] && !l3_q[5] && !l2_q[3] && !l2_q[5];
      end // see RULE22
   end
   assign short_det = pccs_q[`POSD_OCE_BIT] && (|pair_low_q); // see RULE3

   // fault input register: flags set win over software clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fics_q <= `POSD_FICS_RST;
         flag_seen_q <= 4'h0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (detect[i]) begin
               fics_q[`POSD_FLAG_LSB+i] <= 1'b1; // see RULE2
            end else if (wr && hit(paddr, `POSD_FICS_ADDR) &&
                         flag_seen_q[i] && !pwdata[`POSD_FLAG_LSB+i]) begin
               fics_q[`POSD_FLAG_LSB+i] <= 1'b0; // see RULE21
            end
            if (rd && hit(paddr, `POSD_FICS_ADDR) &&
                fics_q[`POSD_FLAG_LSB+i]) begin
               flag_seen_q[i] <= 1'b1;
            end else if (wr && hit(paddr, `POSD_FICS_ADDR)) begin
               flag_seen_q[i] <= 1'b0;
            end
         end
         if (wr && hit(paddr, `POSD_FICS_ADDR)) begin
            fics_q[8:0] <= pwdata[8:0]; // see RULE7
         end
      end
   end

   // pair compare register, same flag discipline
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pccs_q <= `POSD_PCCS_RST;
         osf_seen_q <= 1'b0;
      end else begin
         if (short_det) begin
            pccs_q[`POSD_OSF_BIT] <= 1'b1; // see RULE3
         end else if (wr && hit(paddr, `POSD_PCCS_ADDR) && osf_seen_q &&
                      !pwdata[`POSD_OSF_BIT]) begin
            pccs_q[`POSD_OSF_BIT] <= 1'b0; // see RULE21
         end
         if (rd && hit(paddr, `POSD_PCCS_ADDR) && pccs_q[`POSD_OSF_BIT]) begin
            osf_seen_q <= 1'b1;
         end else if (wr && hit(paddr, `POSD_PCCS_ADDR)) begin
            osf_seen_q <= 1'b0;
         end
         if (wr && hit(paddr, `POSD_PCCS_ADDR)) begin
            pccs_q[9:8] <= pwdata[9:8]; // see RULE7
         end
      end
   end

   // timer mode, run and initial-value register
   assign init_strobe = wr && hit(paddr, `POSD_MODE_ADDR) && pwdata[4];
   assign init_req = pwdata[21:16];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= POSD_NORMAL;
         run_q <= 1'b0;
         comp_init_q <= 6'h00;
         rsync_init_q <= 6'h00;
      end else if (wr && hit(paddr, `POSD_MODE_ADDR)) begin
         case (pwdata[2:0])
            3'h1: mode_q <= POSD_PWM1;
            3'h2: mode_q <= POSD_PWM2;
            3'h3: mode_q <= POSD_PHASE;
            3'h4: mode_q <= POSD_COMP;
            3'h5: mode_q <= POSD_RSYNC;
            default: mode_q <= POSD_NORMAL;
         endcase
         run_q <= pwdata[3]; // timer_count_start image
         comp_init_q <= pwdata[13:8];
         rsync_init_q <= pwdata[29:24];
      end
   end

   // timer output levels across stop, mode change and pin init
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tout_q <= 6'h00; // see RULE8
      end else if (wr && hit(paddr, `POSD_MODE_ADDR)) begin
         if (run_q && !pwdata[3] && mode_q == POSD_COMP) begin
            tout_q <= comp_init_q; // see RULE9
         end else if (run_q && !pwdata[3] && mode_q == POSD_RSYNC) begin
            tout_q <= rsync_init_q; // see RULE10
         end else if (mode_q == POSD_COMP &&
                      (pwdata[2:0] == 3'h0 || pwdata[2:0] == 3'h1)) begin
            tout_q <= 6'h00; // see RULE11
         end else if (mode_q == POSD_RSYNC &&
                      (pwdata[2:0] == 3'h0 || pwdata[2:0] == 3'h1)) begin
            tout_q <= 6'h2A; // see RULE12
         end else if (mode_q == POSD_RSYNC && pwdata[2:0] == 3'h4) begin
            tout_q <= {tout_q[5:3], 1'b0, tout_q[1:0]}; // see RULE13
         end else if (init_strobe && pwdata[2:0] == 3'h1) begin
            tout_q <= {tout_q[5], init_req[4], tout_q[3], init_req[2],
                       tout_q[1], init_req[0]}; // see RULE14
         end else if (init_strobe && pwdata[2:0] == 3'h2) begin
            tout_q <= {init_req[5:3], tout_q[2], init_req[1:0]}; // see RULE15
         end else if (init_strobe) begin
            tout_q <= init_req;
         end
      end
   end

   // any cause releases all six pins at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oe_q <= 6'h00; // see RULE8
      end else if (osc_stop || standby) begin
         oe_q <= 6'h00; // see RULE6
      end else if ((|fics_q[15:12]) || (|detect) ||
                   ((short_det || pccs_q[`POSD_OSF_BIT]) &&
                    pccs_q[`POSD_OIE_BIT])) begin // short needs its enable
         oe_q <= 6'h00; // see RULE4
      end else begin
         oe_q <= timer_pin_select;
      end
   end

   // interrupt from either detector
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= (fics_q[`POSD_PIE_BIT] && (|fics_q[15:12])) ||
                  (pccs_q[`POSD_OIE_BIT] && pccs_q[`POSD_OSF_BIT]);
      end // see RULE5
   end

   // apb read data and error, answered at access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_q <= 32'h0000_0000;
         err_q <= 1'b0;
      end else begin
         err_q <= psel && !penable && !known(paddr);
         if (psel && !penable) begin
            case (paddr)
               `POSD_FICS_ADDR: rdata_q <= {16'h0000, fics_q[15:12],
                                            3'h0, fics_q[8:0]};
               `POSD_PCCS_ADDR: rdata_q <= {16'h0000, pccs_q[15],
                                            5'h00, pccs_q[9:8], 8'h00};
               `POSD_MODE_ADDR: rdata_q <= {2'h0, rsync_init_q, 10'h000,
                  comp_init_q, 4'h0, run_q, mode_q};
               `POSD_STAT_ADDR: rdata_q <= {20'h00000, oe_q, tout_q};
               default: rdata_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   // zero-wait slave: ready held high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= 1'b1;
      end
   end

   assign prdata = rdata_q;
   assign pslverr = err_q; // set at setup edge, so high in access only
   assign pin_oe = oe_q;
   assign timer_out = tout_q;
   assign irq = irq_q;
endmodule
`default_nettype wire

// file: testbench.sv
// self-checking bench for the output shutdown unit
`timescale 1ns/1ns
`default_nettype none
`include "posd_defs.svh"
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin \
   n_mismatch++; $display("BAD %s exp %h got %h", nm, e, s); end end
module testbench;
   import posd_pkg::*;
   localparam logic [11:0] FA = `POSD_FICS_ADDR;
   localparam logic [11:0] PA = `POSD_PCCS_ADDR;
   localparam logic [11:0] MA = `POSD_MODE_ADDR;
   localparam logic [11:0] SA = `POSD_STAT_ADDR;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, e_v;
   logic pready, pslverr, osc_stop = 0, standby = 0, irq;
   logic [3:0] fault_req = 4'h0, f_n;
   logic [5:0] lv, sel = 6'h3F, pin_oe, timer_out, r1, r2;
   int n_mismatch = 0, checks = 0, dv[3] = '{8, 16, 128};
   logic [31:0] exp_q[$];
   posd_top i_posd_top (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fault_shutdown_inputs_n(f_n), .pin_levels(lv),
      .timer_pin_select(sel), .osc_stop(osc_stop), .standby(standby),
      .pin_oe(pin_oe), .timer_out(timer_out), .irq(irq));
   posd_far_end i_posd_far_end (.pclk(pclk), .presetn(presetn),
      .fault_req(fault_req), .pin_oe(pin_oe), .timer_out(timer_out),
      .fault_shutdown_inputs_n(f_n), .pin_levels(lv));
   always #25 pclk = ~pclk;
   // one apb transfer, entered just after a rising edge
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   function automatic logic [31:0] mw(logic [2:0] m, logic run,
      logic ini, logic [5:0] v);
      return {2'h0, r2, 2'h0, v, 2'h0, r1, 3'h0, ini, run, m};
   endfunction
   function automatic logic [31:0] st(logic [5:0] oe, logic [5:0] t);
      return {20'h0, oe, t};
   endfunction
   // read results are checked against the oldest note
   always @(posedge pclk) begin
      if (psel && penable && pready) begin
         `CHK("pslverr", paddr > SA, pslverr)
         if (!pwrite && exp_q.size() > 0) begin
            e_v = exp_q.pop_front();
            `CHK("rdata", e_v, prdata)
         end
      end
   end
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #1000000;
      n_mismatch++;
      wrap_up;
   end
   initial begin
      void'($urandom(32'hBBC6));
      r1 = 6'($urandom);
      r2 = 6'($urandom);
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      rd(FA, 32'h0);
      rd(PA, 32'h0);
      rd(12'h010, 32'h0);
      rd(SA, st(6'h3F, 6'h00));
      $display("test reset done");
      // recovery order: port output, stop, new mode, init, reselect, run
      apb(1'b1, MA, mw(3'h4, 1'b1, 1'b0, 6'h00));
      sel <= 6'h00;
      apb(1'b1, MA, mw(3'h4, 1'b0, 1'b0, 6'h00));
      rd(SA, st(6'h00, r1));
      apb(1'b1, MA, mw(3'h0, 1'b0, 1'b0, 6'h00));
      rd(SA, st(6'h00, 6'h00));
      apb(1'b1, MA, mw(3'h5, 1'b1, 1'b0, 6'h00));
      apb(1'b1, MA, mw(3'h5, 1'b0, 1'b0, 6'h00));
      rd(SA, st(6'h00, r2));
      apb(1'b1, MA, mw(3'h4, 1'b0, 1'b0, 6'h00));
      rd(SA, st(6'h00, r2 & 6'h3B));
      apb(1'b1, MA, mw(3'h5, 1'b0, 1'b0, 6'h00));
      apb(1'b1, MA, mw(3'h1, 1'b0, 1'b0, 6'h00));
      rd(SA, st(6'h00, 6'h2A));
      apb(1'b1, MA, mw(3'h1, 1'b0, 1'b1, 6'h15));
      rd(SA, st(6'h00, 6'h3F));
      apb(1'b1, MA, mw(3'h2, 1'b0, 1'b1, 6'h00));
      rd(SA, st(6'h00, 6'h04));
      sel <= 6'h3F;
      apb(1'b1, MA, mw(3'h2, 1'b1, 1'b0, 6'h00));
      rd(SA, st(6'h3F, 6'h04));
      rd(MA, mw(3'h2, 1'b1, 1'b0, 6'h00));
      $display("test modes done");
      apb(1'b1, FA, 32'h0100);
      fault_req[2] <= 1'b1;
      repeat (10) @(posedge pclk);
      rd(SA, st(6'h00, 6'h04));
      rd(FA, 32'h4100);
      `CHK("irq", 1'b1, irq)
      fault_req[2] <= 1'b0;
      apb(1'b1, FA, 32'h0100);
      rd(FA, 32'h0100);
      rd(SA, st(6'h3F, 6'h04));
      $display("test edge done");
      // each sampling rate: a short low is refused, a long one taken
      for (int m = 1; m < 4; m++) begin
         apb(1'b1, FA, 32'(m));
         fault_req[0] <= 1'b1;
         repeat (12 * dv[m - 1]) @(posedge pclk);
         fault_req[0] <= 1'b0;
         repeat (8) @(posedge pclk);
         rd(FA, 32'(m));
         fault_req[0] <= 1'b1;
         repeat (18 * dv[m - 1] + 20) @(posedge pclk);
         rd(FA, 32'h1000 | 32'(m));
         fault_req[0] <= 1'b0;
         apb(1'b1, FA, 32'(m));
      end
      rd(SA, st(6'h3F, 6'h04));
      $display("test level done");
      apb(1'b1, PA, 32'h0300);
      repeat (10) @(posedge pclk);
      rd(PA, 32'h8300);
      rd(SA, st(6'h00, 6'h04));
      `CHK("irq", 1'b1, irq)
      apb(1'b1, PA, 32'h0000);
      rd(PA, 32'h0);
      rd(SA, st(6'h3F, 6'h04));
      $display("test pair done");
      osc_stop <= 1'b1;
      repeat (5) @(posedge pclk);
      rd(SA, st(6'h00, 6'h04));
      osc_stop <= 1'b0;
      standby <= 1'b1;
      repeat (5) @(posedge pclk);
      rd(SA, st(6'h00, 6'h04));
      standby <= 1'b0;
      repeat (5) @(posedge pclk);
      rd(SA, st(6'h3F, 6'h04));
      $display("test halt done");
      wrap_up;
   end
endmodule
`default_nettype wire
